// ### hdl/bdp_pkg.sv
// constants, state codes and fault indices of the bias driver protection logic
package bdp_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int OV_BLANK_NS     = 1300;
  localparam int OV_BLANK_CYC    = (OV_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int RESTART_MS      = 100;
  localparam int RESTART_CYC     = RESTART_MS * 1000 * CLK_MHZ;
  localparam int SLOW_RISE_US    = 2100;
  localparam int SLOW_DECAY_US   = 180000;
  localparam int SLOW_TRIP_CYC   = SLOW_RISE_US * CLK_MHZ;
  localparam int SLOW_DECAY_DIV  = (SLOW_DECAY_US + SLOW_RISE_US - 1) / SLOW_RISE_US;
  localparam int OCP_SETTLE_US   = 100;
  localparam int OCP_SETTLE_CYC  = OCP_SETTLE_US * CLK_MHZ;
  localparam int CNT_W           = 24;
  localparam int BLANK_W         = 8;
  localparam int DIV_W           = 8;

  // ------------------------------------------------------------------
  // overcurrent level measurement
  // ------------------------------------------------------------------
  localparam int ADC_W           = 12;
  localparam int SOURCE_UA       = 50;
  // band edges halfway between the resistance bands, adc is 1 mV per lsb
  localparam int EDGE1_OHM       = 19700;
  localparam int EDGE2_OHM       = 14250;
  localparam int EDGE3_OHM       = 9900;
  localparam int EDGE4_OHM       = 6600;
  localparam int EDGE5_OHM       = 3700;
  localparam logic [ADC_W-1:0] EDGE1_MV = ADC_W'(EDGE1_OHM * SOURCE_UA / 1000);
  localparam logic [ADC_W-1:0] EDGE2_MV = ADC_W'(EDGE2_OHM * SOURCE_UA / 1000);
  localparam logic [ADC_W-1:0] EDGE3_MV = ADC_W'(EDGE3_OHM * SOURCE_UA / 1000);
  localparam logic [ADC_W-1:0] EDGE4_MV = ADC_W'(EDGE4_OHM * SOURCE_UA / 1000);
  localparam logic [ADC_W-1:0] EDGE5_MV = ADC_W'(EDGE5_OHM * SOURCE_UA / 1000);
  localparam logic [2:0] SIXTHS_RESET   = 3'h6;
  // fast threshold in units of 5/6 A: 6 units is the fixed 5 A
  localparam logic [2:0] FAST_SOFT_UNITS = 3'h6;

  // ------------------------------------------------------------------
  // fault flag indices
  // ------------------------------------------------------------------
  localparam int F_SLOW_OC   = 0;
  localparam int F_FAST_OC   = 1;
  localparam int F_OVERVOLT  = 2;
  localparam int F_THERMAL   = 3;
  localparam int F_DT_RANGE  = 4;
  localparam int F_OCDT_OPEN = 5;
  localparam int F_OCDT_SHRT = 6;
  localparam int F_FSET_SHRT = 7;
  localparam int F_REG_OPEN  = 8;
  localparam int F_REG_LOW   = 9;
  localparam int N_FAULT     = 10;

  // ------------------------------------------------------------------
  // asynchronous comparator input indices
  // ------------------------------------------------------------------
  localparam int A_REG_GOOD  = 0;
  localparam int A_REG_1V    = 1;
  localparam int A_REG_LOW   = 2;
  localparam int A_REG_OPEN  = 3;
  localparam int A_OV_HIGH   = 4;
  localparam int A_OV_CLEAR  = 5;
  localparam int A_HOT       = 6;
  localparam int A_COOL      = 7;
  localparam int A_OCDT_OPEN = 8;
  localparam int A_OCDT_SHRT = 9;
  localparam int A_DT_RANGE  = 10;
  localparam int A_FSET_OPEN = 11;
  localparam int A_FSET_SHRT = 12;
  localparam int A_SLOW_OC   = 13;
  localparam int A_FAST_OC   = 14;
  localparam int A_CYCLE     = 15;
  localparam int A_FOLLOW_OK = 16;
  localparam int A_DISF_PIN  = 17;
  localparam int N_ASYNC     = 18;

  // ------------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_REG_UP  = 3'b000,
    ST_MEASURE = 3'b001,
    ST_RUN     = 3'b011,
    ST_FAULT   = 3'b010,
    ST_LATCH   = 3'b110
  } bdp_state_e;

  typedef enum logic [2:0] {
    M_IDLE       = 3'b000,
    M_ON_SETTLE  = 3'b001,
    M_SAMPLE_ON  = 3'b011,
    M_OFF_SETTLE = 3'b010,
    M_SAMPLE_OFF = 3'b110,
    M_DONE       = 3'b111
  } bdp_meas_e;

endpackage : bdp_pkg

// ### hdl/bdp_meas_if.sv
// handshake between the supervisor and the overcurrent level measurement
`timescale 1ns/1ns
interface bdp_meas_if;
  logic       start;
  logic       done;
  logic [2:0] sixths;

  modport ctrl (output start, input done, input sixths);
  modport unit (input start, output done, output sixths);
endinterface : bdp_meas_if

// ### hdl/bdp_ocp_meas.sv
// start-up measurement of the divider on the overcurrent/dead-time pin
`timescale 1ns/1ns
module bdp_ocp_meas #(
  parameter int unsigned SETTLE_CYCLES = bdp_pkg::OCP_SETTLE_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  bdp_meas_if.unit                       mi,
  input  wire logic [bdp_pkg::ADC_W-1:0] adc_data,
  input  wire logic                      adc_valid,
  output logic                           adc_start,
  output logic                           src_on
);
  import bdp_pkg::*;

  bdp_meas_e           state;
  logic [CNT_W-1:0]    cnt;
  logic [ADC_W-1:0]    v_on;
  logic [ADC_W-1:0]    diff;
  logic                settled;

  // ------------------------------------------------------------------
  // classification of the measured difference
  // ------------------------------------------------------------------
  function automatic logic [2:0] classify(input logic [ADC_W-1:0] d);
    logic [2:0] r;
    r = 3'h6;
    if (d >= EDGE1_MV)
      r = 3'h1;
    else if (d >= EDGE2_MV)
      r = 3'h2;
    else if (d >= EDGE3_MV)
      r = 3'h3;
    else if (d >= EDGE4_MV)
      r = 3'h4;
    else if (d >= EDGE5_MV)
      r = 3'h5;
    return r;
  endfunction : classify

  assign settled = (cnt == CNT_W'(SETTLE_CYCLES - 1));
  // a negative difference means no divider current: treat as lowest resistance
  assign diff    = (v_on > adc_data) ? (v_on - adc_data) : '0;

  // ------------------------------------------------------------------
  // sequence: source on, sample, source off, sample
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= M_IDLE;
      cnt       <= '0;
      v_on      <= '0;
      mi.sixths <= SIXTHS_RESET;
      adc_start <= 1'b0;
    end
    else
    begin
      adc_start <= 1'b0;
      unique case (state)
        M_IDLE:
          if (mi.start)
          begin
            state <= M_ON_SETTLE;
            cnt   <= '0;
          end
        M_ON_SETTLE:
          if (settled)
          begin
            state     <= M_SAMPLE_ON;
            adc_start <= 1'b1;
          end
          else
            cnt <= cnt + 1'b1;
        M_SAMPLE_ON:
          if (adc_valid)
          begin
            v_on  <= adc_data;
            state <= M_OFF_SETTLE;
            cnt   <= '0;
          end
        M_OFF_SETTLE:
          if (settled)
          begin
            state     <= M_SAMPLE_OFF;
            adc_start <= 1'b1;
          end
          else
            cnt <= cnt + 1'b1;
        M_SAMPLE_OFF:
          if (adc_valid)
          begin
            mi.sixths <= classify(diff);
            state     <= M_DONE;
          end
        M_DONE:
          state <= M_DONE;
        default:
          state <= M_IDLE;
      endcase
    end
  end

  // source stays off for good once the level is known
  assign src_on  = (state == M_ON_SETTLE) || (state == M_SAMPLE_ON);
  assign mi.done = (state == M_DONE);

endmodule : bdp_ocp_meas

// ### hdl/bdp_supervisor.sv
// fault supervision and start-up sequencing of the half-bridge bias driver
//
// Summary of operation
// - After regulator settles, pulse the 50 uA source, sample pin on and off.
// - Source stays off after level is chosen; pin then only sets dead time.
// - Voltage difference maps to six slow threshold sixths; highest resistance lowest.
// - Fast threshold fixed at 5 A in soft-start, else five times slow.
// - Slow trip integrates excess current over 2.1 ms; top level is 1 A.
// - Overvoltage must persist 1.3 us continuously before it faults.
// - Overvoltage fault stops switching, pulls disable/fault pin low.
// - After overvoltage wait 100 ms, restart only below recovery level.
// - Over-temperature enters fault mode, stops switching, pulls pin low.
// - Thermal fault held until temperature below shutdown minus hysteresis.
// - Lost clock-follow input only drops synchronisation; switching continues.
// - Pin open/short responses per pin: run, off, fault or 1.2 MHz.
// - Open regulator pin shuts regulator down and latches off until supply cycles.
// - Regulator limit 15 mA below 1 V, 40 mA above, 15 mA after good.
// - Regulator below low level during run latches off until supply cycles.
// - Restart after overcurrent waits 100 ms.
// - Slow timer counts up in 2.1 ms and decays over 180 ms.
`timescale 1ns/1ns
module bdp_supervisor #(
  parameter int unsigned SETTLE_CYCLES  = bdp_pkg::OCP_SETTLE_CYC,
  parameter int unsigned RESTART_CYCLES = bdp_pkg::RESTART_CYC,
  parameter int unsigned TRIP_CYCLES    = bdp_pkg::SLOW_TRIP_CYC
) (
  input  wire logic                       CLK,
  input  wire logic                       ARST_N,
  input  wire logic                       REG_GOOD_CMP,
  input  wire logic                       REG_ABOVE_1V_CMP,
  input  wire logic                       REG_LOW_CMP,
  input  wire logic                       REG_OPEN_CMP,
  input  wire logic                       OV_SHUTDOWN_CMP,
  input  wire logic                       OV_RECOVERED_CMP,
  input  wire logic                       THERMAL_HOT_CMP,
  input  wire logic                       THERMAL_COOL_CMP,
  input  wire logic                       OCDT_OPEN_CMP,
  input  wire logic                       OCDT_SHORT_CMP,
  input  wire logic                       DT_RANGE_CMP,
  input  wire logic                       FSET_OPEN_CMP,
  input  wire logic                       FSET_SHORT_CMP,
  input  wire logic                       SLOW_OC_CMP,
  input  wire logic                       FAST_OC_CMP,
  input  wire logic                       CYCLE_MARK,
  input  wire logic                       FOLLOW_OK,
  input  wire logic                       SOFT_START_ACTIVE,
  input  wire logic [bdp_pkg::ADC_W-1:0]  ADC_DATA,
  input  wire logic                       ADC_VALID,
  output logic                            ADC_START,
  output logic                            CURRENT_SOURCE_ON,
  input  wire logic                       DISABLE_FAULT_PIN_IN,
  output logic                            DISABLE_FAULT_PIN_OUT,
  output logic                            DISABLE_FAULT_PIN_OE,
  output logic                            SWITCH_ENABLE,
  output logic                            REGULATOR_ENABLE,
  output logic                            REG_LIMIT_HIGH,
  output logic                            SLOW_OC_ENABLE,
  output logic [2:0]                      SLOW_OC_SIXTHS,
  output logic [2:0]                      FAST_OC_UNITS,
  output logic                            DEADTIME_FROM_PIN,
  output logic                            MAX_FREQ_SELECT,
  output logic                            FOLLOW_EXT_CLOCK,
  output logic                            FAULT_MODE,
  output logic                            LATCH_OFF,
  output logic [bdp_pkg::N_FAULT-1:0]     FAULT_FLAGS
);
  import bdp_pkg::*;

  logic [N_ASYNC-1:0] raw;
  logic [N_ASYNC-1:0] sync1;
  logic [N_ASYNC-1:0] s;
  bdp_state_e         state;
  logic               reg_good_seen;
  logic               cyc_d;
  logic               cyc_edge;
  logic               excess_seen;
  logic               excess_cycle;
  logic [CNT_W-1:0]   slow_cnt;
  logic [DIV_W-1:0]   decay_div;
  logic               slow_en;
  logic               slow_trip;
  logic [BLANK_W-1:0] ov_cnt;
  logic               ov_trip;
  logic [CNT_W-1:0]   restart_cnt;
  logic               restart_done;
  logic               restart_ok;
  logic               pin_fault;
  logic               leave_fault;
  logic [N_FAULT-1:0] trip;
  logic               run_trip;
  logic               latch_trip;

  bdp_meas_if mi ();

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  assign raw = {DISABLE_FAULT_PIN_IN, FOLLOW_OK, CYCLE_MARK, FAST_OC_CMP, SLOW_OC_CMP,
                FSET_SHORT_CMP, FSET_OPEN_CMP, DT_RANGE_CMP, OCDT_SHORT_CMP,
                OCDT_OPEN_CMP, THERMAL_COOL_CMP, THERMAL_HOT_CMP, OV_RECOVERED_CMP,
                OV_SHUTDOWN_CMP, REG_OPEN_CMP, REG_LOW_CMP, REG_ABOVE_1V_CMP,
                REG_GOOD_CMP};

  for (genvar i = 0; i < N_ASYNC; i++)
  begin : g_sync
    always_ff @(posedge CLK or negedge ARST_N)
    begin
      if (!ARST_N)
      begin
        sync1[i] <= 1'b0;
        s[i]     <= 1'b0;
      end
      else
      begin
        sync1[i] <= raw[i];
        s[i]     <= sync1[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // overcurrent level measurement
  // ------------------------------------------------------------------
  assign mi.start = (state == ST_MEASURE);

  bdp_ocp_meas #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_meas (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .mi        (mi),
    .adc_data  (ADC_DATA),
    .adc_valid (ADC_VALID),
    .adc_start (ADC_START),
    .src_on    (CURRENT_SOURCE_ON)
  );

  // ------------------------------------------------------------------
  // slow overcurrent integrator
  // ------------------------------------------------------------------
  assign cyc_edge = s[A_CYCLE] & ~cyc_d;
  assign slow_en  = (state == ST_RUN) && !SOFT_START_ACTIVE;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cyc_d        <= 1'b0;
      excess_seen  <= 1'b0;
      excess_cycle <= 1'b0;
    end
    else
    begin
      cyc_d <= s[A_CYCLE];
      if (cyc_edge)
      begin
        // verdict of the switching cycle just finished
        excess_cycle <= excess_seen | s[A_SLOW_OC];
        excess_seen  <= 1'b0;
      end
      else
        excess_seen <= excess_seen | s[A_SLOW_OC];
      if (!slow_en)
        excess_cycle <= 1'b0;
    end
  end

  // one step per clock up, one step per decay divider period down
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      slow_cnt  <= '0;
      decay_div <= '0;
    end
    else if (!slow_en)
    begin
      slow_cnt  <= '0;
      decay_div <= '0;
    end
    else if (excess_cycle)
    begin
      decay_div <= '0;
      if (!slow_trip)
        slow_cnt <= slow_cnt + 1'b1;
    end
    else if (decay_div == DIV_W'(SLOW_DECAY_DIV - 1))
    begin
      decay_div <= '0;
      if (slow_cnt != '0)
        slow_cnt <= slow_cnt - 1'b1;
    end
    else
      decay_div <= decay_div + 1'b1;
  end

  assign slow_trip = slow_en && excess_cycle &&
                     (slow_cnt == CNT_W'(TRIP_CYCLES - 1));

  // ------------------------------------------------------------------
  // overvoltage blanking
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ov_cnt <= '0;
    else if (!s[A_OV_HIGH] || ov_trip)
      ov_cnt <= '0;
    else
      ov_cnt <= ov_cnt + 1'b1;
  end

  assign ov_trip = s[A_OV_HIGH] && (ov_cnt == BLANK_W'(OV_BLANK_CYC - 1));

  // ------------------------------------------------------------------
  // fault sources
  // ------------------------------------------------------------------
  always_comb
  begin
    trip              = '0;
    trip[F_SLOW_OC]   = (state == ST_RUN) && slow_trip;
    trip[F_FAST_OC]   = (state == ST_RUN) && s[A_FAST_OC];
    trip[F_OVERVOLT]  = (state == ST_RUN) && ov_trip;
    trip[F_THERMAL]   = (state == ST_RUN) && s[A_HOT];
    trip[F_DT_RANGE]  = (state == ST_RUN) && s[A_DT_RANGE];
    trip[F_OCDT_OPEN] = (state == ST_RUN) && s[A_OCDT_OPEN];
    trip[F_OCDT_SHRT] = (state == ST_RUN) && s[A_OCDT_SHRT];
    trip[F_FSET_SHRT] = (state == ST_RUN) && s[A_FSET_SHRT];
    trip[F_REG_OPEN]  = (state != ST_LATCH) && s[A_REG_OPEN];
    trip[F_REG_LOW]   = (state == ST_RUN) && s[A_REG_LOW];
  end

  assign latch_trip = trip[F_REG_OPEN] | trip[F_REG_LOW];
  assign run_trip   = |trip[F_FSET_SHRT:F_SLOW_OC];

  // ------------------------------------------------------------------
  // restart conditions
  // ------------------------------------------------------------------
  assign restart_done = (restart_cnt == CNT_W'(RESTART_CYCLES - 1));
  assign pin_fault    = s[A_DT_RANGE] | s[A_OCDT_OPEN] | s[A_OCDT_SHRT] | s[A_FSET_SHRT];
  assign restart_ok   = restart_done
                      && s[A_OV_CLEAR]
                      && s[A_COOL]
                      && !s[A_HOT]
                      && !pin_fault;
  assign leave_fault  = (state == ST_FAULT) && restart_ok && !latch_trip;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      restart_cnt <= '0;
    else if (state != ST_FAULT)
      restart_cnt <= '0;
    else if (!restart_done)
      restart_cnt <= restart_cnt + 1'b1;
  end

  // ------------------------------------------------------------------
  // supervisor state
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      state <= ST_REG_UP;
    else if (latch_trip)
      state <= ST_LATCH;
    else
    begin
      unique case (state)
        ST_REG_UP:
          if (s[A_REG_GOOD])
            state <= ST_MEASURE;
        ST_MEASURE:
          if (mi.done)
            state <= ST_RUN;
        ST_RUN:
          if (run_trip)
            state <= ST_FAULT;
        ST_FAULT:
          if (leave_fault)
            state <= ST_RUN;
        ST_LATCH:
          state <= ST_LATCH; // only a supply cycle clears it
        default:
          state <= ST_LATCH;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // sticky fault flags
  // ------------------------------------------------------------------
  // a new trip in the cycle of the restart clear still lands
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      FAULT_FLAGS <= '0;
    else
      FAULT_FLAGS <= trip | (FAULT_FLAGS & ~{N_FAULT{leave_fault}});
  end

  // ------------------------------------------------------------------
  // regulator
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      reg_good_seen <= 1'b0;
    else if (s[A_REG_GOOD])
      reg_good_seen <= 1'b1;
  end

  assign REGULATOR_ENABLE = (state != ST_LATCH);
  assign REG_LIMIT_HIGH   = REGULATOR_ENABLE && !reg_good_seen && s[A_REG_1V];

  // ------------------------------------------------------------------
  // thresholds
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      SLOW_OC_SIXTHS <= SIXTHS_RESET;
      FAST_OC_UNITS  <= FAST_SOFT_UNITS;
    end
    else
    begin
      SLOW_OC_SIXTHS <= mi.sixths;
      // outside soft start the fast limit is five times the slow one, in units of 5/6 A
      FAST_OC_UNITS  <= SOFT_START_ACTIVE ? FAST_SOFT_UNITS : mi.sixths;
    end
  end

  assign SLOW_OC_ENABLE    = slow_en;
  assign DEADTIME_FROM_PIN = mi.done;

  // ------------------------------------------------------------------
  // switching and pin outputs
  // ------------------------------------------------------------------
  // grounded disable pin only inhibits switching, it is no fault
  assign SWITCH_ENABLE         = (state == ST_RUN) && s[A_DISF_PIN];
  assign DISABLE_FAULT_PIN_OUT = 1'b0;
  assign DISABLE_FAULT_PIN_OE  = (state != ST_RUN);
  assign MAX_FREQ_SELECT       = s[A_FSET_OPEN];
  // a lost follow clock falls back to the frequency-set pin
  assign FOLLOW_EXT_CLOCK      = SWITCH_ENABLE && !SOFT_START_ACTIVE && s[A_FOLLOW_OK];
  assign FAULT_MODE            = (state == ST_FAULT) || (state == ST_LATCH);
  assign LATCH_OFF             = (state == ST_LATCH);

endmodule : bdp_supervisor

// ### test/bdp_checker.sv
// port assertions for the bias driver protection supervisor
`timescale 1ns/1ns
module bdp_checker #(
  parameter int unsigned RESTART_CYCLES = 50
) (
  input wire logic                        CLK,
  input wire logic                        ARST_N,
  input wire logic                        OV_SHUTDOWN_CMP,
  input wire logic                        SOFT_START_ACTIVE,
  input wire logic                        CURRENT_SOURCE_ON,
  input wire logic                        DISABLE_FAULT_PIN_OE,
  input wire logic                        SWITCH_ENABLE,
  input wire logic                        REGULATOR_ENABLE,
  input wire logic [2:0]                  SLOW_OC_SIXTHS,
  input wire logic [2:0]                  FAST_OC_UNITS,
  input wire logic                        DEADTIME_FROM_PIN,
  input wire logic                        FAULT_MODE,
  input wire logic                        LATCH_OFF,
  input wire logic [bdp_pkg::N_FAULT-1:0] FAULT_FLAGS
);
  import bdp_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ----------------------------------------------------------------
  // cycles spent in fault mode
  // ----------------------------------------------------------------
  logic [31:0] fault_cnt;
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      fault_cnt <= '0;
    else
      fault_cnt <= FAULT_MODE ? fault_cnt + 32'h0000_0001 : '0;
  end
  property p_src_off; DEADTIME_FROM_PIN |-> !CURRENT_SOURCE_ON; endproperty
  a_src_off: assert property (p_src_off) else $error("source on after level chosen");
  property p_fast_soft; SOFT_START_ACTIVE [*2] |-> FAST_OC_UNITS == FAST_SOFT_UNITS; endproperty
  a_fast_soft: assert property (p_fast_soft) else $error("fast level not 5 A");
  property p_fast_track;
    (DEADTIME_FROM_PIN && !SOFT_START_ACTIVE) [*3] |-> FAST_OC_UNITS == SLOW_OC_SIXTHS;
  endproperty
  a_fast_track: assert property (p_fast_track) else $error("fast not five times slow");
  property p_fault_stop; FAULT_MODE |-> !SWITCH_ENABLE && DISABLE_FAULT_PIN_OE; endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("switching in fault");
  property p_latch_reg; LATCH_OFF |-> !REGULATOR_ENABLE; endproperty
  a_latch_reg: assert property (p_latch_reg) else $error("regulator on in latch");
  property p_latch_hold; LATCH_OFF |=> LATCH_OFF && FAULT_MODE; endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released");
  property p_ov_blank;
    $rose(FAULT_FLAGS[F_OVERVOLT]) |-> $past(OV_SHUTDOWN_CMP, 10) && $past(OV_SHUTDOWN_CMP, 120);
  endproperty
  a_ov_blank: assert property (p_ov_blank) else $error("overvoltage not blanked");
  property p_restart; $fell(FAULT_MODE) |-> fault_cnt >= RESTART_CYCLES - 1; endproperty
  a_restart: assert property (p_restart) else $error("restart too early");
  c_run: cover property (DEADTIME_FROM_PIN && SWITCH_ENABLE);
  c_ov: cover property ($rose(FAULT_FLAGS[F_OVERVOLT]));
  c_latch: cover property ($rose(LATCH_OFF));
endmodule : bdp_checker
bind bdp_supervisor bdp_checker #(.RESTART_CYCLES(RESTART_CYCLES)) chk (.*);

// ### test/bdp_supervisor_tb.sv
// self-checking bench for the bias driver protection supervisor
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module bdp_supervisor_tb;
  import bdp_pkg::*;
  logic CLK, ARST_N, REG_GOOD_CMP, REG_ABOVE_1V_CMP, REG_LOW_CMP, REG_OPEN_CMP;
  logic OV_SHUTDOWN_CMP, OV_RECOVERED_CMP, THERMAL_HOT_CMP, THERMAL_COOL_CMP, OCDT_OPEN_CMP;
  logic OCDT_SHORT_CMP, DT_RANGE_CMP, FSET_OPEN_CMP, FSET_SHORT_CMP, SLOW_OC_CMP, FAST_OC_CMP;
  logic CYCLE_MARK, FOLLOW_OK, SOFT_START_ACTIVE, ADC_VALID, ADC_START, CURRENT_SOURCE_ON;
  logic DISABLE_FAULT_PIN_IN, DISABLE_FAULT_PIN_OUT, DISABLE_FAULT_PIN_OE, SWITCH_ENABLE;
  logic REGULATOR_ENABLE, REG_LIMIT_HIGH, SLOW_OC_ENABLE, DEADTIME_FROM_PIN, MAX_FREQ_SELECT;
  logic FOLLOW_EXT_CLOCK, FAULT_MODE, LATCH_OFF;
  logic [11:0] ADC_DATA;
  logic [2:0]  SLOW_OC_SIXTHS, FAST_OC_UNITS;
  logic [9:0]  FAULT_FLAGS;
  logic [11:0] diffs [6] = '{12'h03E8, 12'h0320, 12'h0258, 12'h0190, 12'h00FA, 12'h0064};
  int fails, comparisons;
  bdp_supervisor #(.SETTLE_CYCLES(8), .RESTART_CYCLES(50), .TRIP_CYCLES(20)) dut (.*);
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // bounded wait: 0 conversion request, 1 fault entry, 2 fault exit
  task automatic wait_on(input int sel);
    int n;
    n = 0;
    while (!((sel == 0 && ADC_START === 1'b1) || (sel == 1 && FAULT_MODE === 1'b1)
             || (sel == 2 && FAULT_MODE === 1'b0)))
    begin
      n++;
      if (n > 300)
      begin
        fails++;
        $display("[ERR] wait %0d exp 1 got 0", sel);
        close_out();
      end
      step(1);
    end
  endtask : wait_on
  task automatic rst;
    {REG_GOOD_CMP, REG_LOW_CMP, REG_OPEN_CMP, OV_SHUTDOWN_CMP} = '0;
    {THERMAL_HOT_CMP, OCDT_OPEN_CMP, OCDT_SHORT_CMP, DT_RANGE_CMP, FSET_OPEN_CMP} = '0;
    {FSET_SHORT_CMP, SLOW_OC_CMP, FAST_OC_CMP, CYCLE_MARK, ADC_VALID, ADC_DATA} = '0;
    {OV_RECOVERED_CMP, THERMAL_COOL_CMP, DISABLE_FAULT_PIN_IN, FOLLOW_OK} = 4'hF;
    {REG_ABOVE_1V_CMP, SOFT_START_ACTIVE} = 2'h3;
    ARST_N = 1'b0;
    step(20);
    `CHK("oe", 1'b1, DISABLE_FAULT_PIN_OE)
    ARST_N = 1'b1;
    step(3);
  endtask : rst
  task automatic t_measure(input logic [11:0] diff, input logic [2:0] exp);
    `CHK("lim40", 1'b1, REG_LIMIT_HIGH)
    REG_GOOD_CMP = 1'b1;
    wait_on(0);
    `CHK("src_on", 1'b1, CURRENT_SOURCE_ON)
    ADC_DATA = diff + 12'h00C8;
    ADC_VALID = 1'b1;
    step(1);
    ADC_VALID = 1'b0;
    wait_on(0);
    `CHK("src_off", 1'b0, CURRENT_SOURCE_ON)
    ADC_DATA = 12'h00C8;
    ADC_VALID = 1'b1;
    step(1);
    ADC_VALID = 1'b0;
    step(4);
    `CHK("dt_pin", 1'b1, DEADTIME_FROM_PIN)
    `CHK("lim15", 1'b0, REG_LIMIT_HIGH)
    `CHK("sixths", exp, SLOW_OC_SIXTHS)
    `CHK("fast_ss", 3'h6, FAST_OC_UNITS)
    SOFT_START_ACTIVE = 1'b0;
    step(4);
    `CHK("fast", exp, FAST_OC_UNITS)
    `CHK("slow_en", 1'b1, SLOW_OC_ENABLE)
  endtask : t_measure
  task automatic t_ov;
    OV_SHUTDOWN_CMP = 1'b1;
    step(100);
    OV_SHUTDOWN_CMP = 1'b0;
    step(10);
    `CHK("ov_short", 1'b0, FAULT_MODE)
    OV_SHUTDOWN_CMP = 1'b1;
    OV_RECOVERED_CMP = 1'b0;
    step(125);
    `CHK("ov_blank", 1'b0, FAULT_MODE)
    wait_on(1);
    OV_SHUTDOWN_CMP = 1'b0;
    `CHK("ov_flag", 1'b1, FAULT_FLAGS[F_OVERVOLT])
    `CHK("ov_oe", 1'b1, DISABLE_FAULT_PIN_OE)
    step(80);
    `CHK("ov_hold", 1'b1, FAULT_MODE)
    OV_RECOVERED_CMP = 1'b1;
    wait_on(2);
    step(3);
    `CHK("ov_rerun", 1'b1, SWITCH_ENABLE)
  endtask : t_ov
  task automatic t_thermal;
    THERMAL_HOT_CMP = 1'b1;
    THERMAL_COOL_CMP = 1'b0;
    wait_on(1);
    `CHK("hot_flag", 1'b1, FAULT_FLAGS[F_THERMAL])
    THERMAL_HOT_CMP = 1'b0;
    step(80);
    `CHK("hot_hold", 1'b1, FAULT_MODE)
    THERMAL_COOL_CMP = 1'b1;
    wait_on(2);
  endtask : t_thermal
  task automatic t_fast;
    {SLOW_OC_CMP, CYCLE_MARK} = 2'h3;
    step(15);
    `CHK("slow_int", 1'b0, FAULT_MODE)
    wait_on(1);
    {SLOW_OC_CMP, CYCLE_MARK} = 2'h0;
    `CHK("slow_flag", 1'b1, FAULT_FLAGS[F_SLOW_OC])
    wait_on(2);
    FAST_OC_CMP = 1'b1;
    wait_on(1);
    FAST_OC_CMP = 1'b0;
    `CHK("fast_flag", 1'b1, FAULT_FLAGS[F_FAST_OC])
    step(30);
    `CHK("fast_wait", 1'b1, FAULT_MODE)
    wait_on(2);
    FOLLOW_OK = 1'b0;
    step(10);
    `CHK("no_follow", 1'b1, SWITCH_ENABLE)
    `CHK("follow", 1'b0, FOLLOW_EXT_CLOCK)
  endtask : t_fast
  task automatic t_latch;
    REG_LOW_CMP = 1'b1;
    step(5);
    `CHK("latch", 1'b1, LATCH_OFF)
    `CHK("reg_off", 1'b0, REGULATOR_ENABLE)
    REG_LOW_CMP = 1'b0;
    step(100);
    `CHK("latch_hold", 1'b1, LATCH_OFF)
  endtask : t_latch
  initial
  begin
    fails = 0;
    comparisons = 0;
    for (int i = 0; i < 6; i++)
    begin
      rst();
      t_measure(diffs[i], 3'(i + 1));
    end
    t_ov();
    t_thermal();
    t_fast();
    t_latch();
    close_out();
  end
endmodule : bdp_supervisor_tb
